// file: hw/upes_event_status.sv
// Top of the host port event status block with an AXI4-Lite register slave.
// Assumes mclk keeps running; the internal clock enable only gates other events.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ns
module upes_event_status
   import upes_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   // Clock and reset
   input  wire logic              mclk,
   input  wire logic              reset,
   // AXI4-Lite write address and data
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // AXI4-Lite read
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Over-current pins
   input  wire logic              port0_overcurrent_pin_a,
   input  wire logic              port0_overcurrent_pin_b,
   input  wire logic              port1_overcurrent_pin,
   // Line states and link events per port
   input  wire logic [1:0]        port0LineState,
   input  wire logic [1:0]        port1LineState,
   input  wire logic [1:0]        portDisconnect,
   input  wire logic [1:0]        portEofLate,
   // Setup transaction results
   input  wire logic              setupDone,
   input  wire logic [2:0]        setupResult,
   // Port control and interrupt
   output logic [1:0]             portIdle,
   output logic                   irqReq
);
   // ****************************************************************
   // State
   // ****************************************************************
   logic [15:0] p0Status_ff, p1Status_ff;
   logic [15:0] p0Enable_ff, p1Enable_ff;
   logic [15:0] ctrl_ff;
   logic [1:0]  busAct_ff;
   logic [1:0]  portIdle_ff;
   logic [2:0]  ocPrev_ff;
   logic [1:0]  failCnt_ff;
   logic        irq_ff;
   logic        awHeld_ff, wHeld_ff, bValid_ff, rValid_ff;
   logic [ADDR_W-1:0] awAddr_ff;
   logic [31:0] wData_ff, rData_ff;
   logic [3:0]  wStrb_ff;
   logic [1:0]  bResp_ff, rResp_ff;

   // ****************************************************************
   // Port detectors
   // ****************************************************************
   upes_port_if portBus [2] ();
   logic [1:0] lsChg, attach, detach, frame_end_error_flag;
   logic [1:0] lineSt [2];
   assign lineSt[0] = port0LineState;
   assign lineSt[1] = port1LineState;

   // One detector per port
   for (genvar p = 0; p < 2; p++) begin : g_port
      assign portBus[p].lineState   = lineSt[p];
      assign portBus[p].portEnabled = busAct_ff[p];
      assign portBus[p].hostMode    = ctrl_ff[UPES_HOST_BIT];
      assign portBus[p].eofLate     = portEofLate[p];
      assign portBus[p].disconnect  = portDisconnect[p];
      assign lsChg[p]  = portBus[p].lsChange;
      assign attach[p] = portBus[p].attach;
      assign detach[p] = portBus[p].detach;
      assign frame_end_error_flag[p] = portBus[p].eofError;
      upes_port_detect u_det (
         .mclk  (mclk),
         .reset (reset),
         .port  (portBus[p].det)
      );
   end

   // ****************************************************************
   // Event decode
   // ****************************************************************
   logic        clkOn, setupFail, setupAck, ocChg0, ocChg1, setupOk;
   logic [15:0] p0Set, p1Set;
   assign clkOn = ctrl_ff[UPES_CLK_EN_BIT];
   assign ocChg0 = (port0_overcurrent_pin_a != ocPrev_ff[0])
                   || (port0_overcurrent_pin_b != ocPrev_ff[1]);
   assign ocChg1 = port1_overcurrent_pin != ocPrev_ff[2];
   assign setupOk   = setupResult == UPES_HS_ACK;
   assign setupAck  = setupDone && setupOk && clkOn;
   assign setupFail = setupDone && !setupOk && clkOn
                      && (failCnt_ff == 2'(UPES_SETUP_TRIES - 1));
   // only OC and line state change ignore clock enable
   assign p0Set = (16'(ocChg0) << UPES_OVRC_BIT) | (16'(lsChg[0]) << UPES_LSCHG_BIT)
                | (16'(detach[0] && clkOn) << UPES_DISC_BIT)
                | (16'(attach[0] && clkOn) << UPES_CONN_BIT)
                | (16'(frame_end_error_flag[0] && clkOn) << UPES_EOFE_BIT)
                | (16'(setupFail) << UPES_SFAIL_BIT) | (16'(setupAck) << UPES_SETUP_ACK_BIT);
   assign p1Set = (16'(ocChg1) << UPES_OVRC_BIT) | (16'(lsChg[1]) << UPES_LSCHG_BIT)
                | (16'(detach[1] && clkOn) << UPES_DISC_BIT)
                | (16'(attach[1] && clkOn) << UPES_CONN_BIT)
                | (16'(frame_end_error_flag[1] && clkOn) << UPES_EOFE_BIT);

   // ****************************************************************
   // Bus decode
   // ****************************************************************
   logic        wrFire, rdFire;
   logic [7:0]  wrIdx, rdIdx;
   logic [15:0] wMask, wLow;
   assign wrFire = awHeld_ff && wHeld_ff && !bValid_ff;
   assign rdFire = s_axi_arvalid && !rValid_ff;
   assign wrIdx  = 8'(awAddr_ff >> 2);
   assign rdIdx  = 8'(s_axi_araddr >> 2);
   assign wMask  = {{8{wStrb_ff[1]}}, {8{wStrb_ff[0]}}};
   assign wLow   = wData_ff[15:0];
   logic wrP0St, wrP1St, wrP0En, wrP1En, wrCtrl, wrHit, rdHit;
   assign wrP0St = wrFire && wrIdx == UPES_PORT0_EVENT_STATUS_OFS;
   assign wrP1St = wrFire && wrIdx == UPES_PORT1_EVENT_STATUS_OFS;
   assign wrP0En = wrFire && wrIdx == UPES_PORT0_ENABLE_OFS;
   assign wrP1En = wrFire && wrIdx == UPES_PORT1_ENABLE_OFS;
   assign wrCtrl = wrFire && wrIdx == UPES_DEVICE_STATE_CTRL_OFS;
   assign wrHit  = wrP0St | wrP1St | wrP0En | wrP1En | wrCtrl
                   | (wrIdx == UPES_PORT0_SYSTEM_STATUS_OFS)
                   | (wrIdx == UPES_PORT1_SYSTEM_STATUS_OFS);

   // zero clears; set wins over clear
   logic [15:0] p0Clr, p1Clr, nxt_p0Status, nxt_p1Status;
   assign p0Clr = wrP0St ? (wMask & ~wLow) : 16'h0000;
   assign p1Clr = wrP1St ? (wMask & ~wLow) : 16'h0000;
   assign nxt_p0Status = ((p0Status_ff & ~p0Clr) | p0Set) & UPES_P0_MASK;
   assign nxt_p1Status = ((p1Status_ff & ~p1Clr) | p1Set) & UPES_P1_MASK;

   // Read mux; live pin and line levels
   logic [31:0] rdVal;
   always_comb begin
      rdHit = 1'b1;
      rdVal = 32'h0000_0000;
      case (rdIdx)
         UPES_PORT0_EVENT_STATUS_OFS:  rdVal = {16'h0000, p0Status_ff};
         UPES_PORT1_EVENT_STATUS_OFS:  rdVal = {16'h0000, p1Status_ff};
         UPES_PORT0_ENABLE_OFS:        rdVal = {16'h0000, p0Enable_ff};
         UPES_PORT1_ENABLE_OFS:        rdVal = {16'h0000, p1Enable_ff};
         UPES_DEVICE_STATE_CTRL_OFS:   rdVal = {16'h0000, ctrl_ff};
         UPES_PORT0_SYSTEM_STATUS_OFS:
            rdVal = 32'({port0_overcurrent_pin_b, port0_overcurrent_pin_a}) << UPES_OC_MON_LSB
                  | 32'(port0LineState) << UPES_LINE_STATE_LSB
                  | 32'(busAct_ff[0]) << UPES_BUS_ACT_BIT;
         UPES_PORT1_SYSTEM_STATUS_OFS:
            rdVal = 32'({1'b0, port1_overcurrent_pin}) << UPES_OC_MON_LSB
                  | 32'(port1LineState) << UPES_LINE_STATE_LSB
                  | 32'(busAct_ff[1]) << UPES_BUS_ACT_BIT;
         default:                      rdHit = 1'b0;
      endcase
   end

   // ****************************************************************
   // AXI4-Lite handshakes
   // ****************************************************************
   // Address and data taken independently, answered once both are held
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         awHeld_ff <= 1'b0;
         wHeld_ff  <= 1'b0;
         bValid_ff <= 1'b0;
         awAddr_ff <= '0;
         wData_ff  <= 32'h0000_0000;
         wStrb_ff  <= 4'h0;
         bResp_ff  <= 2'b00;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_ff <= 1'b1;
            awAddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_ff <= 1'b1;
            wData_ff <= s_axi_wdata;
            wStrb_ff <= s_axi_wstrb;
         end
         if (wrFire) begin
            awHeld_ff <= 1'b0;
            wHeld_ff  <= 1'b0;
            bValid_ff <= 1'b1;
            bResp_ff  <= wrHit ? 2'b00 : 2'b10; // SLVERR on unmapped
         end else if (bValid_ff && s_axi_bready) begin
            bValid_ff <= 1'b0;
         end
      end
   end

   // Read channel: one-cycle answer registered from the mux
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         rValid_ff <= 1'b0;
         rData_ff  <= 32'h0000_0000;
         rResp_ff  <= 2'b00;
      end else if (rdFire) begin
         rValid_ff <= 1'b1;
         rData_ff  <= rdVal;
         rResp_ff  <= rdHit ? 2'b00 : 2'b10;
      end else if (rValid_ff && s_axi_rready) begin
         rValid_ff <= 1'b0;
      end
   end

   // ****************************************************************
   // Registers and event state
   // ****************************************************************
   // status clear at reset
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         p0Status_ff <= UPES_STATUS_RST;
         p1Status_ff <= UPES_STATUS_RST;
         p0Enable_ff <= UPES_ENABLE_RST;
         p1Enable_ff <= UPES_ENABLE_RST;
         ctrl_ff     <= UPES_CTRL_RST;
         ocPrev_ff   <= 3'b000;
         failCnt_ff  <= 2'b00;
      end else begin
         p0Status_ff <= nxt_p0Status;
         p1Status_ff <= nxt_p1Status;
         ocPrev_ff   <= {port1_overcurrent_pin, port0_overcurrent_pin_b,
                         port0_overcurrent_pin_a};
         if (wrP0En) p0Enable_ff <= (p0Enable_ff & ~wMask) | (wLow & wMask);
         if (wrP1En) p1Enable_ff <= (p1Enable_ff & ~wMask) | (wLow & wMask);
         if (wrCtrl) ctrl_ff <= (ctrl_ff & ~wMask) | (wLow & wMask);
         if (setupDone && clkOn)
            failCnt_ff <= (setupOk || setupFail) ? 2'b00 : failCnt_ff + 2'b01;
      end
   end

   // Bus activity enables; hardware clear beats software set
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         busAct_ff   <= 2'b00;
         portIdle_ff <= 2'b00;
      end else begin
         for (int p = 0; p < 2; p++) begin
            if ((detach[p] || frame_end_error_flag[p]) && clkOn) begin
               busAct_ff[p]   <= 1'b0;
               portIdle_ff[p] <= 1'b1;
            end else if (wrCtrl && wStrb_ff[0]) begin
               busAct_ff[p]   <= wLow[UPES_BUS_ACT_BIT + 2 + p];
               portIdle_ff[p] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) irq_ff <= 1'b0;
      else irq_ff <= |(nxt_p0Status & p0Enable_ff) || |(nxt_p1Status & p1Enable_ff);
   end

   // Output drive straight from flops
   assign s_axi_awready = !awHeld_ff && !bValid_ff;
   assign s_axi_wready  = !wHeld_ff && !bValid_ff;
   assign s_axi_bvalid  = bValid_ff;
   assign s_axi_bresp   = bResp_ff;
   assign s_axi_arready = !rValid_ff;
   assign s_axi_rvalid  = rValid_ff;
   assign s_axi_rdata   = rData_ff;
   assign s_axi_rresp   = rResp_ff;
   assign portIdle      = portIdle_ff;
   assign irqReq        = irq_ff;
endmodule // upes_event_status

// file: hw/upes_pkg.sv
// Package for the host port event status block: offsets, fields, resets, timing.
// Assumes a 25 MHz controller clock and a 32-bit AXI4-Lite register bus.
package upes_pkg;
   // ****************************************************************
   // Register offsets (word indices)
   // ****************************************************************
   localparam logic [7:0] UPES_PORT0_EVENT_STATUS_OFS = 8'h42; // index, byte addr = 4x
   localparam logic [7:0] UPES_PORT1_EVENT_STATUS_OFS = 8'h44;
   localparam logic [7:0] UPES_PORT0_ENABLE_OFS       = 8'h48;
   localparam logic [7:0] UPES_PORT1_ENABLE_OFS       = 8'h4A;
   localparam logic [7:0] UPES_PORT0_SYSTEM_STATUS_OFS= 8'h4C;
   localparam logic [7:0] UPES_PORT1_SYSTEM_STATUS_OFS= 8'h4E;
   localparam logic [7:0] UPES_DEVICE_STATE_CTRL_OFS  = 8'h50;

   // ****************************************************************
   // Event status field positions
   // ****************************************************************
   localparam int UPES_OVRC_BIT  = 15;
   localparam int UPES_LSCHG_BIT = 14;
   localparam int UPES_DISC_BIT  = 12;
   localparam int UPES_CONN_BIT  = 11;
   localparam int UPES_EOFE_BIT  = 6;
   localparam int UPES_SFAIL_BIT = 5;
   localparam int UPES_SETUP_ACK_BIT = 4;
   localparam logic [15:0] UPES_P0_MASK = 16'hD870;
   localparam logic [15:0] UPES_P1_MASK = 16'hD840;

   // System status / control fields
   localparam int UPES_LINE_STATE_LSB = 0;  // 2-bit line state
   localparam int UPES_OC_MON_LSB     = 14; // 2-bit overcurrent monitor
   localparam int UPES_BUS_ACT_BIT    = 4;
   localparam int UPES_HOST_BIT       = 0;  // host mode in control reg
   localparam int UPES_CLK_EN_BIT     = 1;  // internal clock enable

   // ****************************************************************
   // Reset values and timing
   // ****************************************************************
   localparam logic [15:0] UPES_STATUS_RST = 16'h0000;
   localparam logic [15:0] UPES_ENABLE_RST = 16'h0000;
   localparam logic [15:0] UPES_CTRL_RST   = 16'h0000;
   localparam int UPES_CLK_HZ        = 25_000_000;
   localparam int UPES_ATTACH_NS     = 2500;
   localparam int UPES_ATTACH_CYC    = (UPES_ATTACH_NS * (UPES_CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int UPES_SETUP_TRIES   = 3;

   // Line states
   localparam logic [1:0] UPES_LS_SE0 = 2'b00;
   localparam logic [1:0] UPES_LS_J   = 2'b01;
   localparam logic [1:0] UPES_LS_K   = 2'b10;
   localparam logic [1:0] UPES_LS_SE1 = 2'b11;

   // Setup handshake result codes
   typedef enum logic [2:0] {
      UPES_HS_ACK     = 3'b000,
      UPES_HS_TIMEOUT = 3'b001,
      UPES_HS_CORRUPT = 3'b010,
      UPES_HS_NAK     = 3'b011,
      UPES_HS_NYET    = 3'b100,
      UPES_HS_STALL   = 3'b101
   } upes_hs_e;
endpackage

// file: hw/upes_port_detect.sv
// Per-port line event detector: line change, attach qualification, detach, EOF.
// Assumes synchronous inputs on mclk.
`timescale 1ns/1ns
module upes_port_detect
   import upes_pkg::*;
(
   // Clock and reset
   input wire logic  mclk,
   input wire logic  reset,
   // Port signals
   upes_port_if.det  port
);
   logic [1:0]  prevState_ff;
   logic [7:0]  holdCnt_ff;
   logic        armed_ff;
   logic        lsChange_ff;
   logic        attach_ff;
   logic        isJk;
   logic        stateMoved;

   // Decode of the raw line state
   assign isJk       = (port.lineState == UPES_LS_J) || (port.lineState == UPES_LS_K);
   assign stateMoved = port.lineState != prevState_ff;

   // Track line state; SE1 moves raise no change event
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         prevState_ff <= UPES_LS_SE0;
         lsChange_ff  <= 1'b0;
      end else begin
         prevState_ff <= port.lineState;
         lsChange_ff  <= stateMoved && (port.lineState != UPES_LS_SE1)
                         && (prevState_ff != UPES_LS_SE1);
      end
   end

   // Attach qualifier: new J or K held for the full time
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         holdCnt_ff   <= 8'h00;
         armed_ff     <= 1'b0;
         attach_ff    <= 1'b0;
      end else begin
         attach_ff <= 1'b0;
         if (stateMoved) begin
            holdCnt_ff   <= 8'h00;
            armed_ff     <= isJk;
         end else if (armed_ff) begin
            if (holdCnt_ff == 8'(UPES_ATTACH_CYC - 1)) begin
               armed_ff  <= 1'b0;
               attach_ff <= port.hostMode && !port.portEnabled;
            end else begin
               holdCnt_ff <= holdCnt_ff + 8'h01;
            end
         end
      end
   end

   assign port.detach   = port.disconnect && port.portEnabled && port.hostMode;
   assign port.eofError = port.eofLate && port.portEnabled && port.hostMode;
   assign port.lsChange = lsChange_ff;
   assign port.attach   = attach_ff;
endmodule // upes_port_detect

// file: hw/upes_port_if.sv
// Interface carrying one port's detector signals between top and detector.
// Assumes both ends share mclk.
`timescale 1ns/1ns
interface upes_port_if;
   logic [1:0] lineState;   // Current line state
   logic       portEnabled; // Bus activity enable for the port
   logic       hostMode;    // Host function selected
   logic       eofLate;     // Transaction open at EOF2 pulse
   logic       disconnect;  // Disconnect seen by transceiver
   logic       lsChange;    // Line state changed pulse
   logic       attach;      // Attach qualified pulse
   logic       detach;      // Detach pulse
   logic       eofError;    // EOF error pulse
   modport det (input lineState, portEnabled, hostMode, eofLate, disconnect,
                output lsChange, attach, detach, eofError);
   modport top (output lineState, portEnabled, hostMode, eofLate, disconnect,
                input lsChange, attach, detach, eofError);
endinterface // upes_port_if

// file: testbench/upes_event_status_properties.sv
// Checker for the port event status block: bus answers and event side effects.
// Assumes it is bound into upes_event_status and sees only that module's ports.
`timescale 1ns/1ns
module upes_event_status_properties
   import upes_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   // Clock, reset and bus handshakes
   input wire logic              mclk, reset, s_axi_awvalid, s_axi_awready,
   input wire logic              s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready,
   input wire logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
   // Bus payload
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [31:0]       s_axi_rdata,
   input wire logic [1:0]        s_axi_rresp,
   // Port events and interrupt
   input wire logic [1:0]        portIdle, portDisconnect, portEofLate,
   input wire logic              irqReq
);
   // ****************************************************************
   // Relations
   // ****************************************************************
   localparam logic [ADDR_W-1:0] P1A = ADDR_W'({UPES_PORT1_EVENT_STATUS_OFS, 2'b00});
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   logic wroteAny_ff; // No enable can be set before the first write address
   // First write address taken since reset
   always_ff @(posedge mclk or posedge reset)
      if (reset) wroteAny_ff <= 1'b0;
      else if (s_axi_awvalid && s_axi_awready) wroteAny_ff <= 1'b1;
   sequence wrBoth;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rdTake(logic [ADDR_W-1:0] a);
      s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
   endsequence
   a_write_resp: assert property (wrBoth |-> ##[1:2] s_axi_bvalid)
      else $error("write answer late");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer repeated");
   a_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer repeated");
   a_unmapped_err: assert property (rdTake('0) |=> s_axi_rresp == 2'b10 && s_axi_rdata == '0)
      else $error("unmapped read not refused");
   a_p1_reserved: assert property (
      rdTake(P1A) |=> (s_axi_rdata[15:0] & ~UPES_P1_MASK) == 16'h0000)
      else $error("port 1 spare bits set");
   a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
      else $error("upper read half not zero");
   a_idle_cause: assert property (
      $rose(portIdle[0]) |-> $past(portDisconnect[0]) || $past(portEofLate[0]))
      else $error("port forced idle without cause");
   a_irq_quiet: assert property (!wroteAny_ff |-> !irqReq)
      else $error("interrupt before any enable");
endmodule // upes_event_status_properties
bind upes_event_status upes_event_status_properties #(.ADDR_W(ADDR_W)) u_props (
   .mclk, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .s_axi_rready, .s_axi_araddr, .s_axi_rdata, .s_axi_rresp, .portIdle,
   .portDisconnect, .portEofLate, .irqReq);

// file: testbench/upes_event_status_tb.sv
// Bench for the port event status block: bus tasks, read queue, peer model.
// Assumes the peer model drives every port-side input except the pins.
`timescale 1ns/1ns
module upes_event_status_tb import upes_pkg::*; ;
   // ****************************************************************
   // Signals and design
   // ****************************************************************
   localparam logic [11:0] P0S = {2'b00, UPES_PORT0_EVENT_STATUS_OFS, 2'b00},
      P1S = {2'b00, UPES_PORT1_EVENT_STATUS_OFS, 2'b00}, P0E = {2'b00, UPES_PORT0_ENABLE_OFS, 2'b00},
      S0 = {2'b00, UPES_PORT0_SYSTEM_STATUS_OFS, 2'b00}, CT = {2'b00, UPES_DEVICE_STATE_CTRL_OFS, 2'b00};
   logic        mclk = 1'b0, reset = 1'b1, pinA = 1'b0, pinB = 1'b0, pin1 = 1'b0;
   logic        awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
   logic [11:0] aw = 12'h000, ar = 12'h000;
   logic [15:0] wd = 16'h0000, seed = 16'h000C;
   logic        awRdy, wRdy, bv, arRdy, rv, irqReq, sDone;
   logic [31:0] rdata;
   logic [1:0]  bresp, rresp, ls0, ls1, disc, eof, portIdle;
   logic [2:0]  sRes;
   logic [33:0] q[$]; // Expected {resp, data} per read, oldest first
   int          n_errors = 0, compares = 0;
   upes_event_status #(.ADDR_W(12)) DUT (
      .mclk, .reset, .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awRdy),
      .s_axi_wdata({16'h0000, wd}), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wRdy),
      .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ar),
      .s_axi_arvalid(arv), .s_axi_arready(arRdy), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rv), .s_axi_rready(rr), .port0_overcurrent_pin_a(pinA),
      .port0_overcurrent_pin_b(pinB), .port1_overcurrent_pin(pin1), .port0LineState(ls0),
      .port1LineState(ls1), .portDisconnect(disc), .portEofLate(eof), .setupDone(sDone),
      .setupResult(sRes), .portIdle, .irqReq);
   upes_usb_peer peer (.mclk, .ls0, .ls1, .disc, .eof, .sDone, .sRes);
   initial forever #20 mclk = ~mclk;
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic chk(input logic [33:0] g, input logic [33:0] e);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("FAIL t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic stop_test();
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Bounded wait sampled mid-cycle, away from the launching edge
   task automatic waitHi(ref logic s, ref int n);
      do begin
         @(negedge mclk);
         n++;
      end while (s !== 1'b1 && n < 99);
      if (n >= 99) begin
         n_errors++;
         stop_test();
      end
   endtask
   // Write: both channels offered together, each released when taken
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      logic pa, pw;
      int n;
      pa = 1'b1;
      pw = 1'b1;
      n = 0;
      @(posedge mclk);
      aw <= a;
      wd <= d;
      {awv, wv, br} <= 3'h7;
      while ((pa || pw) && n < 99) begin
         @(negedge mclk);
         pa = pa && !awRdy;
         pw = pw && !wRdy;
         n++;
         @(posedge mclk);
         {awv, wv} <= {pa, pw};
      end
      waitHi(bv, n);
      @(posedge mclk);
      br <= 1'b0;
   endtask
   // Read: expectation queued first, answer checked by the watcher
   task automatic rd(input logic [11:0] a, input logic [15:0] d, input logic [1:0] r);
      int n;
      n = 0;
      q.push_back({r, 16'h0000, d});
      @(posedge mclk);
      ar <= a;
      {arv, rr} <= 2'h3;
      waitHi(arRdy, n);
      @(posedge mclk);
      arv <= 1'b0;
      waitHi(rv, n);
      @(posedge mclk);
      rr <= 1'b0;
   endtask
   // Watcher takes the oldest expectation for each read answer
   always @(negedge mclk) begin
      if (rv === 1'b1 && rr === 1'b1) chk({rresp, rdata}, q.pop_front());
   end
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   initial begin
      repeat (16) @(posedge mclk);
      reset <= 1'b0;
      rd(P0S, 16'h0000, 2'h0);
      rd(P1S, 16'h0000, 2'h0);
      rd(12'h000, 16'h0000, 2'h2);
      $display("test reset done");
      @(posedge mclk) pinA <= 1'b1;
      @(posedge mclk) pinB <= 1'b1;
      @(posedge mclk) pin1 <= 1'b1;
      repeat (4) @(posedge mclk);
      rd(P0S, 16'h8000, 2'h0);
      rd(S0, 16'hC000, 2'h0);
      rd(S0, 16'hC000, 2'h0);
      seed = lfsr(seed);
      wr(P0S, seed | 16'h8000);
      rd(P0S, 16'h8000, 2'h0);
      wr(P0E, 16'hC000);
      @(negedge mclk) chk(34'(irqReq), 34'h1);
      seed = lfsr(seed);
      wr(P0S, seed & 16'h7FFF);
      @(negedge mclk) chk(34'(irqReq), 34'h0);
      rd(P0S, 16'h0000, 2'h0);
      wr(P1S, 16'hFFFF);
      rd(P1S, 16'h8000, 2'h0);
      $display("test overcurrent done");
      wr(CT, 16'h0003);
      peer.line(UPES_LS_J);
      repeat (40) @(posedge mclk);
      rd(P0S, 16'h4000, 2'h0);
      repeat (40) @(posedge mclk);
      rd(P0S, 16'h4800, 2'h0);
      rd(S0, 16'hC001, 2'h0);
      wr(CT, 16'h0043);
      rd(S0, 16'hC011, 2'h0);
      peer.unplug(1'b1);
      repeat (4) @(posedge mclk);
      @(negedge mclk) chk(34'(portIdle), 34'h1);
      rd(S0, 16'hC001, 2'h0);
      rd(P0S, 16'h5800, 2'h0);
      peer.unplug(1'b0);
      wr(CT, 16'h0043);
      @(negedge mclk) chk(34'(portIdle), 34'h0);
      peer.eofPulse();
      repeat (4) @(posedge mclk);
      @(negedge mclk) chk(34'(portIdle), 34'h1);
      rd(S0, 16'hC001, 2'h0);
      rd(P0S, 16'h5840, 2'h0);
      $display("test line events done");
      wr(P0S, 16'h0000);
      for (int i = 1; i < 8; i++) begin
         peer.setup(3'(i < 7 ? (i - 1) % 5 + 1 : 0));
         if (i % 3 == 0) begin
            rd(P0S, 16'h0020, 2'h0);
            wr(P0S, 16'h0000);
         end
      end
      rd(P0S, 16'h0010, 2'h0);
      $display("test setup done");
      wr(CT, 16'h0001);
      wr(P0S, 16'h0000);
      @(posedge mclk) pinA <= 1'b0;
      peer.line(UPES_LS_K);
      repeat (80) @(posedge mclk);
      rd(P0S, 16'hC000, 2'h0);
      rd(S0, 16'h8002, 2'h0);
      @(negedge mclk) chk(34'(irqReq), 34'h1);
      wr(P0E, 16'h0000);
      @(negedge mclk) chk(34'(irqReq), 34'h0);
      $display("test clock stopped done");
      stop_test();
   end
endmodule // upes_event_status_tb

// file: testbench/upes_usb_peer.sv
// Peer model: attached device line state, link events and setup replies.
// Assumes the bench calls its tasks; outputs change just after mclk rises.
`timescale 1ns/1ns
module upes_usb_peer (
   // Clock
   input  wire logic mclk,
   // Port side
   output logic [1:0] ls0, ls1, disc, eof,
   output logic       sDone,
   output logic [2:0] sRes
);
   initial {ls0, ls1, disc, eof, sDone, sRes} = 12'h000;
   // Line state is held until the next call
   task automatic line(input logic [1:0] v);
      @(posedge mclk);
      ls0 <= v;
   endtask
   task automatic unplug(input logic v);
      @(posedge mclk);
      disc[0] <= v;
   endtask
   // Frame overrun is a one-cycle pulse
   task automatic eofPulse();
      @(posedge mclk);
      eof[0] <= 1'b1;
      @(posedge mclk);
      eof[0] <= 1'b0;
   endtask
   // Reply code is junk outside its strobe, so stale codes are never trusted
   task automatic setup(input logic [2:0] r);
      @(posedge mclk);
      sDone <= 1'b1;
      sRes <= r;
      @(posedge mclk);
      sDone <= 1'b0;
      sRes <= ~r;
   endtask
endmodule // upes_usb_peer
